/* File: hw/tmc_channel.sv */
// Timer channel counter core with register port.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "tmc_defines.svh"

// Notes on behaviour
// R1: Count clock is the operation clock or valid input edges, by source bit.
// R2: Divided operation clock is a one-cycle pulse per 2^r period, r 0..15.
// R3: The counter updates one system clock after each count clock pulse.
// R4: Without filter the edge count clock follows the input by 1 to 2 periods.
// R5: The input is sampled on the operation clock and edges raise pulses.
// R6: With filter, edge detection is two operation clocks later, 3 to 4 total.
// R7: Writing the start bit without the stop bit sets the enabled flag and runs the channel.
// R8: Interval: counter holds until first count clock, reloads, then decrements.
// R9: Interval and capture raise an interrupt at start when start-irq is set.
// R10: Interval: at zero, interrupt, reload from data register, keep counting.
// R11: Event mode: start loads data immediately, then decrements on edges.
// R12: Capture: first count clock loads zero, later clocks increment.
// R13: Capture: each valid edge copies counter to data, interrupts, restarts at zero.
// R14: One-count modes: start while stopped waits for trigger, counter holds.
// R15: One-count: rising input edge loads data, then decrement on count clocks.
// R16: One-count: at zero, interrupt, counter becomes FFFFH, counting stops.
// R17: Capture-one-count: rising edge loads zero and starts incrementing.
// R18: Capture-one-count: falling edge copies counter to data and interrupts.
// R19: Operation clock, start trigger and interrupt are single-cycle pulses.
// R20: Filter enable selects two-sample match plus sync, or sync alone.
// R21: Counter and data are 16 bits with plain binary up and down counting.
module tmc_channel (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic TIMER_IN,
	input wire logic [2:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	output logic CHANNEL_INTERRUPT,
	output logic CHANNEL_ENABLED
);
	logic [15:0] channel_mode_reg_r;
	logic [7:0] prescaler_select_reg_r;
	logic noise_filter_enable_r;
	tmc_pkg::tmc_word_t channel_data_reg_r;
	tmc_pkg::tmc_word_t channel_count_reg_r;
	tmc_pkg::tmc_state_t state_r;
	logic [14:0] pre_r;
	logic [3:0] ratio;
	logic [14:0] mask;
	logic op_clock_r;
	logic start_trig_r;
	logic rise, fall;
	logic edge_ok;
	logic count_clock;
	logic [2:0] func;
	logic [1:0] edge_sel;
	logic start_wr, stop_wr;

	assign func = channel_mode_reg_r[`TMC_MODE_FUNC_MSB:`TMC_MODE_FUNC_LSB];
	assign edge_sel = channel_mode_reg_r[`TMC_MODE_EDGE_MSB:`TMC_MODE_EDGE_LSB];
	assign start_wr = WR && (ADDR == `TMC_OFS_START) && WDATA[`TMC_START_BIT];
	assign stop_wr = WR && (ADDR == `TMC_OFS_START) && WDATA[`TMC_STOP_BIT];

	// ======================================================================
	// Register writes.
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			channel_mode_reg_r <= `TMC_RST_WORD;
			prescaler_select_reg_r <= 8'h00;
			noise_filter_enable_r <= 1'b0;
		end else if (WR) begin
			unique case (ADDR)
				`TMC_OFS_MODE: channel_mode_reg_r <= WDATA;
				`TMC_OFS_PRESCALE: prescaler_select_reg_r <= WDATA[7:0];
				`TMC_OFS_FILTER: noise_filter_enable_r <= WDATA[0];
				default: ;
			endcase
		end
	end

	// ======================================================================
	// Operation clock: a free prescaler gives a one-cycle pulse every 2^r clocks.
	always_comb begin
		ratio = `TMC_RST_RATIO;
		if (channel_mode_reg_r[`TMC_MODE_CKS_LO]) begin
			ratio = prescaler_select_reg_r[7:4];
		end else begin
			ratio = prescaler_select_reg_r[3:0];
		end
		mask = 15'((`TMC_PRE_ONE << ratio) - `TMC_PRE_ONE);
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pre_r <= 15'h0000;
			op_clock_r <= 1'b0;
		end else begin
			pre_r <= 15'(pre_r + `TMC_PRE_ONE);
			op_clock_r <= ((pre_r & mask) == mask); // R2 R19
		end
	end

	// ======================================================================
	// Input conditioning on the operation clock.
	tmc_input_cond i_tmc_input_cond (
		.clk(CORE_CLK),
		.arst_n(ARST_N),
		.pin(TIMER_IN),
		.mck(op_clock_r),
		.filt_en(noise_filter_enable_r),
		.rise(rise),
		.fall(fall)
	);

	always_comb begin
		edge_ok = 1'b0;
		unique case (edge_sel)
			`TMC_EDGE_RISE: edge_ok = rise;
			`TMC_EDGE_BOTH: edge_ok = rise | fall;
			default: edge_ok = fall;
		endcase
	end

	assign count_clock = channel_mode_reg_r[`TMC_MODE_CCS] ? edge_ok : op_clock_r; // R1

	// ======================================================================
	// Counter, data register, state and interrupt.
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= tmc_pkg::ST_STOP;
			channel_count_reg_r <= `TMC_CNT_FULL;
			channel_data_reg_r <= `TMC_RST_WORD;
			CHANNEL_INTERRUPT <= 1'b0;
			CHANNEL_ENABLED <= 1'b0;
			start_trig_r <= 1'b0;
		end else begin
			CHANNEL_INTERRUPT <= 1'b0; // R19
			start_trig_r <= 1'b0;
			if (WR && ADDR == `TMC_OFS_DATA) begin
				channel_data_reg_r <= WDATA;
			end
			if (stop_wr) begin
				state_r <= tmc_pkg::ST_STOP;
				CHANNEL_ENABLED <= 1'b0;
			end else if (start_wr && (func == `TMC_FUNC_ONE || func == `TMC_FUNC_CAP_ONE)) begin
				if (!CHANNEL_ENABLED) begin
					state_r <= tmc_pkg::ST_WAIT_TRIG; // R14
					CHANNEL_ENABLED <= 1'b1; // R7
				end
			end else if (start_wr && func == `TMC_FUNC_EVENT) begin
				channel_count_reg_r <= channel_data_reg_r; // R11
				state_r <= tmc_pkg::ST_RUN;
				CHANNEL_ENABLED <= 1'b1; // R7
			end else if (start_wr) begin
				state_r <= tmc_pkg::ST_WAIT_CLK; // R8
				CHANNEL_ENABLED <= 1'b1; // R7
			end else begin
				unique case (state_r)
					tmc_pkg::ST_STOP: ;
					tmc_pkg::ST_WAIT_CLK: begin
						if (count_clock) begin
							start_trig_r <= 1'b1; // R19
							state_r <= tmc_pkg::ST_RUN;
							CHANNEL_INTERRUPT <= channel_mode_reg_r[`TMC_MODE_SIRQ]; // R9
							if (func == `TMC_FUNC_CAPTURE) begin
								channel_count_reg_r <= `TMC_CNT_ZERO; // R12
							end else begin
								channel_count_reg_r <= channel_data_reg_r; // R8
							end
						end
					end
					tmc_pkg::ST_WAIT_TRIG: begin
						if (rise) begin
							start_trig_r <= 1'b1;
							state_r <= tmc_pkg::ST_RUN;
							if (func == `TMC_FUNC_CAP_ONE) begin
								channel_count_reg_r <= `TMC_CNT_ZERO; // R17
							end else begin
								channel_count_reg_r <= channel_data_reg_r; // R15
							end
						end
					end
					tmc_pkg::ST_RUN: begin
						if (func == `TMC_FUNC_CAPTURE && edge_ok) begin
							channel_data_reg_r <= channel_count_reg_r; // R13
							channel_count_reg_r <= `TMC_CNT_ZERO; // R13
							CHANNEL_INTERRUPT <= 1'b1;
						end else if (func == `TMC_FUNC_CAP_ONE && fall) begin
							channel_data_reg_r <= channel_count_reg_r; // R18
							CHANNEL_INTERRUPT <= 1'b1;
							state_r <= tmc_pkg::ST_WAIT_TRIG;
						end else if (count_clock) begin // R3
							if (func == `TMC_FUNC_CAPTURE || func == `TMC_FUNC_CAP_ONE) begin
								channel_count_reg_r <= 16'(channel_count_reg_r + `TMC_CNT_ONE); // R21
							end else if (channel_count_reg_r == `TMC_CNT_ZERO) begin
								CHANNEL_INTERRUPT <= 1'b1;
								if (func == `TMC_FUNC_ONE) begin
									channel_count_reg_r <= `TMC_CNT_FULL; // R16
									state_r <= tmc_pkg::ST_WAIT_TRIG;
								end else begin
									channel_count_reg_r <= channel_data_reg_r; // R10
								end
							end else begin
								channel_count_reg_r <= 16'(channel_count_reg_r - `TMC_CNT_ONE); // R21
							end
						end
					end
				endcase
			end
		end
	end

	// ======================================================================
	// Read port: data stand in the cycle after the read strobe only.
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= `TMC_RST_WORD;
		end else if (RD) begin
			unique case (ADDR)
				`TMC_OFS_MODE: RDATA <= channel_mode_reg_r;
				`TMC_OFS_DATA: RDATA <= channel_data_reg_r;
				`TMC_OFS_COUNT: RDATA <= channel_count_reg_r;
				`TMC_OFS_STATUS: RDATA <= {15'h0000, CHANNEL_ENABLED};
				`TMC_OFS_PRESCALE: RDATA <= {8'h00, prescaler_select_reg_r};
				`TMC_OFS_FILTER: RDATA <= {15'h0000, noise_filter_enable_r};
				default: RDATA <= `TMC_RST_WORD;
			endcase
		end else begin
			RDATA <= `TMC_RST_WORD;
		end
	end
endmodule

/* File: hw/tmc_defines.svh */
// Offsets, field positions, reset values and counter constants of the timer channel.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
// ======================================================================
// Register offsets
`define TMC_OFS_MODE 3'h0
`define TMC_OFS_DATA 3'h1
`define TMC_OFS_COUNT 3'h2
`define TMC_OFS_START 3'h3
`define TMC_OFS_STATUS 3'h4
`define TMC_OFS_PRESCALE 3'h5
`define TMC_OFS_FILTER 3'h6
// ======================================================================
// Mode register fields
`define TMC_MODE_SIRQ 0
`define TMC_MODE_FUNC_LSB 1
`define TMC_MODE_FUNC_MSB 3
`define TMC_MODE_EDGE_LSB 6
`define TMC_MODE_EDGE_MSB 7
`define TMC_MODE_CCS 12
`define TMC_MODE_CKS_LO 14
`define TMC_MODE_CKS_HI 15
// ======================================================================
// Function codes and edge codes
`define TMC_FUNC_INTERVAL 3'h0
`define TMC_FUNC_CAPTURE 3'h1
`define TMC_FUNC_EVENT 3'h2
`define TMC_FUNC_ONE 3'h4
`define TMC_FUNC_CAP_ONE 3'h6
`define TMC_EDGE_FALL 2'h0
`define TMC_EDGE_RISE 2'h1
`define TMC_EDGE_BOTH 2'h2
// ======================================================================
// Start register fields, reset values, counter constants
`define TMC_START_BIT 0
`define TMC_STOP_BIT 1
`define TMC_RST_WORD 16'h0000
`define TMC_CNT_ZERO 16'h0000
`define TMC_CNT_ONE 16'h0001
`define TMC_CNT_FULL 16'hffff
`define TMC_RST_RATIO 4'h0
`define TMC_PRE_ONE 15'h0001
`endif

/* File: hw/tmc_input_cond.sv */
// Timer input synchroniser, optional noise filter and edge detector.
`timescale 1ns/1ps
module tmc_input_cond (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pin,
	input wire logic mck,
	input wire logic filt_en,
	output logic rise,
	output logic fall
);
	logic s1_r, s2_r, s3_r, lvl_r;
	logic smp_r, smp2_r, flt_r, prev_r;
	logic cur;

	// ======================================================================
	// Three-flop synchroniser; a change counts once the last two agree.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				lvl_r <= s3_r;
			end
		end
	end

	// ======================================================================
	// Sampling on the operation clock, with two-sample match when filtered.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			smp_r <= 1'b0;
			smp2_r <= 1'b0;
			flt_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (mck) begin
			smp_r <= lvl_r; // R5
			smp2_r <= smp_r;
			if (smp_r == smp2_r) begin
				flt_r <= smp2_r; // R20
			end
			prev_r <= cur;
		end
	end

	assign cur = filt_en ? flt_r : smp_r; // R6

	// ======================================================================
	// Edge pulses, one system clock wide, aligned to the operation clock.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			rise <= mck & cur & ~prev_r; // R4
			fall <= mck & ~cur & prev_r;
		end
	end
endmodule

/* File: hw/tmc_pkg.sv */
// Types shared by the timer channel modules.
package tmc_pkg;
	typedef enum logic [1:0] {ST_STOP, ST_WAIT_CLK, ST_RUN, ST_WAIT_TRIG} tmc_state_t;
	typedef logic [15:0] tmc_word_t;
endpackage

/* File: sim/tmc_channel_props.sv */
// Port checker for the timer channel.
`timescale 1ns/1ps
module tmc_channel_props (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic [2:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic CHANNEL_INTERRUPT,
	input wire logic CHANNEL_ENABLED
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_start;
		WR && ADDR == 3'h3 && WDATA[0] && !WDATA[1];
	endsequence
	sequence s_stop;
		WR && ADDR == 3'h3 && WDATA[1];
	endsequence
	a_start_sets_en: assert property (s_start |=> CHANNEL_ENABLED)
		else $error("start write left channel disabled");
	a_stop_clears_en: assert property (s_stop |=> !CHANNEL_ENABLED)
		else $error("stop write left channel enabled");
	a_rise_needs_start: assert property ($rose(CHANNEL_ENABLED) |-> $past(WR && ADDR == 3'h3 && WDATA[0]))
		else $error("channel enabled without start write");
	a_fall_needs_stop: assert property ($fell(CHANNEL_ENABLED) |-> $past(WR && ADDR == 3'h3 && WDATA[1]))
		else $error("channel disabled without stop write");
	a_irq_needs_run: assert property (CHANNEL_INTERRUPT |-> $past(CHANNEL_ENABLED))
		else $error("interrupt from a stopped channel");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data outside read slot");
	a_status_read: assert property (RD && ADDR == 3'h4 |=> RDATA == {15'h0000, $past(CHANNEL_ENABLED)})
		else $error("status read disagrees with enabled flag");
	a_dead_read: assert property (RD && (ADDR == 3'h3 || ADDR == 3'h7) |=> RDATA == 16'h0000)
		else $error("write-only or unmapped read not zero");
endmodule
bind tmc_channel tmc_channel_props i_props (.CORE_CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.CHANNEL_INTERRUPT, .CHANNEL_ENABLED);

/* File: sim/tmc_channel_tb_top.sv */
// Self-checking bench for the timer channel counter core.
`timescale 1ns/1ps
module tmc_channel_tb_top;
	logic clk;
	logic arst_n = 1'b0;
	logic timer_in, irq, en;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] width = 16'h0001;
	logic [15:0] rdata, v;
	int n_mismatch = 0;
	int comparisons = 0;
	int gap;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	tmc_pin_model i_tmc_pin_model (.clk(clk), .high_cycles(width), .go(go), .pin(timer_in));
	tmc_channel i_tmc_channel (.CORE_CLK(clk), .ARST_N(arst_n), .TIMER_IN(timer_in), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CHANNEL_INTERRUPT(irq), .CHANNEL_ENABLED(en));
	task automatic wreg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		comparisons++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h, want %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic rchk(input logic [2:0] a, input logic [15:0] e);
		rreg(a, v);
		cmp(v, e, e);
	endtask
	task automatic wait_irq(output int n);
		n = 1;
		@(negedge clk);
		while (irq !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300) begin
			n_mismatch++;
			$display("mismatch at %0t: no interrupt", $time);
		end
	endtask
	task automatic pulse(input logic [15:0] w);
		@(posedge clk);
		width <= w;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		// ======================================================================
		// Reset values and refused accesses.
		rchk(3'h0, 16'h0000);
		rchk(3'h1, 16'h0000);
		wreg(3'h2, 16'h1234);
		rchk(3'h2, 16'hffff);
		rchk(3'h4, 16'h0000);
		rchk(3'h7, 16'h0000);
		// ======================================================================
		// Interval mode with start interrupt.
		wreg(3'h1, 16'h0003);
		wreg(3'h0, 16'h0001);
		wreg(3'h3, 16'h0001);
		wait_irq(gap);
		cmp(16'(gap), 16'h0002, 16'h0002);
		cmp(16'(en), 16'h0001, 16'h0001);
		wait_irq(gap);
		cmp(16'(gap), 16'h0004, 16'h0004);
		wait_irq(gap);
		cmp(16'(gap), 16'h0004, 16'h0004);
		// Second prescaler field at ratio 1: four count clocks take eight cycles.
		wreg(3'h5, 16'h0010);
		wreg(3'h0, 16'h4001);
		wait_irq(gap);
		wait_irq(gap);
		wait_irq(gap);
		cmp(16'(gap), 16'h0008, 16'h0008);
		// ======================================================================
		// Capture mode, rising edges.
		wreg(3'h3, 16'h0002);
		wreg(3'h0, 16'h0043);
		wreg(3'h3, 16'h0001);
		wait_irq(gap);
		cmp(16'(gap), 16'h0002, 16'h0002);
		pulse(16'h0006);
		wait_irq(gap);
		repeat (20) @(posedge clk);
		pulse(16'h0006);
		wait_irq(gap);
		rreg(3'h1, v);
		// Rises are 29 clocks apart and the counter restarts at zero on each capture.
		cmp(v, 16'h001b, 16'h001d);
		// ======================================================================
		// Event counter, without and with the noise filter.
		wreg(3'h3, 16'h0002);
		wreg(3'h1, 16'h0005);
		wreg(3'h0, 16'h1044);
		wreg(3'h3, 16'h0001);
		rchk(3'h2, 16'h0005);
		for (int i = 0; i < 2; i++) begin
			pulse(16'h0004);
			repeat (10) @(posedge clk);
		end
		rchk(3'h2, 16'h0003);
		wreg(3'h6, 16'h0001);
		pulse(16'h0008);
		// Without the filter the count would already be 2 at this read.
		repeat (7) @(posedge clk);
		rchk(3'h2, 16'h0003);
		rchk(3'h2, 16'h0002);
		wreg(3'h6, 16'h0000);
		// ======================================================================
		// One-count: hold until trigger, then run to terminal.
		wreg(3'h3, 16'h0002);
		wreg(3'h1, 16'h0004);
		wreg(3'h0, 16'h0008);
		wreg(3'h3, 16'h0001);
		repeat (5) @(posedge clk);
		rchk(3'h2, 16'h0002);
		pulse(16'h0002);
		wait_irq(gap);
		cmp(16'(gap), 16'h000b, 16'h000d);
		rchk(3'h2, 16'hffff);
		// ======================================================================
		// Capture and one-count: high width of 30 cycles.
		wreg(3'h3, 16'h0002);
		wreg(3'h0, 16'h000c);
		wreg(3'h3, 16'h0001);
		pulse(16'h001e);
		wait_irq(gap);
		rreg(3'h1, v);
		cmp(v, 16'h001c, 16'h001f);
		results();
	end
endmodule

/* File: sim/tmc_pin_model.sv */
// Behavioural source of the external timer input.
`timescale 1ns/1ps
module tmc_pin_model (
	input wire logic clk,
	input wire logic [15:0] high_cycles,
	input wire logic go,
	output logic pin
);
	initial pin = 1'b0;
	// The pin moves right after a clock edge; the block still treats it as asynchronous.
	always @(posedge clk) begin
		if (go) begin
			pin <= 1'b1;
			repeat (high_cycles) @(posedge clk);
			pin <= 1'b0;
		end
	end
endmodule
